// ==== rtl/ptpc_pkg.sv ====
// Package: register map, field layout and constants of the periodic timer block
package ptpc_pkg;
  localparam int          CNT_W          = 10;
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_CMPA      = 12'h004;
  localparam logic [11:0] ADDR_CAPB      = 12'h008;
  localparam logic [11:0] ADDR_PERIOD    = 12'h00C;
  localparam logic [11:0] ADDR_COUNT     = 12'h010;
  localparam logic [11:0] ADDR_STATUS    = 12'h014;
  localparam logic [11:0] ADDR_INSRC     = 12'h018;
  // Control register fields
  localparam int          F_RUN          = 0;
  localparam int          F_MODE_LO      = 1;
  localparam int          F_PIN_LO       = 3;
  localparam int          F_CLRSRC       = 5;
  localparam int          F_INIT_LVL     = 6;
  localparam int          F_POL_INV      = 7;
  localparam int          F_CAPSRC       = 8;
  localparam int          F_CAPCLR_LO    = 9;
  // Input source select: bits 7:6 pick the capture input
  localparam int          F_INSRC_LO     = 6;
  localparam logic [1:0]  INSRC_PIN      = 2'h0;
  // Status fields, flags A and P write one to clear
  localparam int          F_FLAG_A       = 0;
  localparam int          F_FLAG_P       = 1;
  localparam int          F_FLAG_LVL     = 2;
  localparam logic [1:0]  MODE_CMP       = 2'h0;
  localparam logic [1:0]  MODE_CAPTURE   = 2'h1;
  localparam logic [1:0]  MODE_PWM       = 2'h2;
  localparam logic [1:0]  PIN_NONE       = 2'h0;
  localparam logic [1:0]  PIN_LOW        = 2'h1;
  localparam logic [1:0]  PIN_HIGH       = 2'h2;
  localparam logic [1:0]  PIN_ACTIVE     = 2'h3;
  localparam logic [1:0]  EDGE_RISE      = 2'h0;
  localparam logic [1:0]  EDGE_FALL      = 2'h1;
  localparam logic [1:0]  EDGE_BOTH      = 2'h2;
  localparam logic [1:0]  EDGE_OFF       = 2'h3;
  localparam logic [1:0]  CCLR_RISE      = 2'h1;
  localparam logic [1:0]  CCLR_FALL      = 2'h2;
  localparam logic [1:0]  CCLR_BOTH      = 2'h3;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam int          TCLK_DIV_DFLT  = 4;
endpackage

// ==== rtl/ptpc_edge.sv ====
// Edge detector with registered previous level, qualified by the timer tick
`timescale 1ns/1ns
module ptpc_edge (
  input  wire logic i_clk,   // System clock
  input  wire logic i_rst_b, // Async reset, active low
  input  wire logic i_tick,  // Timer clock enable
  input  wire logic i_lvl,   // Level to watch
  output logic      o_rise,  // Rising edge, one tick
  output logic      o_fall,  // Falling edge, one tick
  output logic      o_lvl    // Level as sampled at last tick
);
  logic prev_r;

  // Sampled only on ticks, so pulses under one tick may be missed
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_r <= 1'b0;
    end else if (i_tick) begin
      prev_r <= i_lvl;
    end
  end

  assign o_rise = i_tick & i_lvl & ~prev_r;
  assign o_fall = i_tick & ~i_lvl & prev_r;
  assign o_lvl  = prev_r;
endmodule // ptpc_edge

// ==== rtl/ptpc_timer.sv ====
// Periodic timer: PWM, single pulse and capture modes behind an AHB-Lite slave
// What this block does
// - PWM period is period value, zero gives 1024
// - Duty at or above period gives full duty
// - PWM counting runs while pin action 00/01/10
// - PWM ignores clear source select bit
// - Run bit rise starts count and pulse
// - Trigger pin rising edge sets run bit in single pulse
// - Compare A match ends pulse, clears run
// - Single pulse counter zeroes only on start
// - Single pulse ignores period and clear select
// - Mode 01 is capture, source bit picks pin
// - Input select bits 7:6 pick capture signal
// - Pin action picks edge, 11 disables capture
// - Capture edge stores count, raises interrupt
// - Capture counter runs until run bit falls
// - Period match clears counter, raises interrupt
// - Capture clear select adds edge clears
// - Pulses under one tick may be missed
// - Flag A set, level flag half tick later
// - Capture latency under one and half ticks
// - Mode 10 is PWM, initial level, pin action
// - Polarity invert bit reverses PWM output
`timescale 1ns/1ns
module ptpc_timer
  import ptpc_pkg::*;
#(
  parameter int TCLK_DIV = TCLK_DIV_DFLT
) (
  input  wire logic        I_CLK_SYS,    // System clock, 100 MHz
  input  wire logic        I_RST_B,      // Async reset, active low
  input  wire logic        I_HSEL,       // AHB slave select
  input  wire logic [31:0] I_HADDR,      // AHB address
  input  wire logic [1:0]  I_HTRANS,     // AHB transfer type
  input  wire logic        I_HWRITE,     // AHB write
  input  wire logic [2:0]  I_HSIZE,      // AHB size
  input  wire logic [31:0] I_HWDATA,     // AHB write data
  input  wire logic        I_HREADY,     // AHB bus ready
  output logic      [31:0] O_HRDATA,     // AHB read data
  output logic             O_HREADYOUT,  // AHB slave ready
  output logic             O_HRESP,      // AHB response, always OKAY
  input  wire logic        I_EXT_TRIG,   // External trigger pin, also capture input
  input  wire logic        I_CAP_PIN,    // External capture pin
  input  wire logic        I_CMP_CAP,    // Internal comparator capture signal
  output logic             O_TMR_OUT,    // Timer output pin
  output logic             O_TMR_EVENT   // Timer interrupt request pulse
);
  // Timer clock enable from divider
  logic [15:0] div_r;
  logic        tick;
  assign tick = (div_r == 16'(TCLK_DIV - 1));
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      div_r <= 16'h0000;
    end else if (tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // Registers
  logic [31:0]      ctrl_r;
  logic [CNT_W-1:0] cmpa_r;
  logic [CNT_W-1:0] capb_r;
  logic [CNT_W-1:0] period_r;
  logic [CNT_W-1:0] cnt_r;
  logic [1:0]       insrc_r;
  logic [2:0]       stat_r;
  logic             run_r;

  logic [1:0] mode;
  logic [1:0] pin_act;
  logic [1:0] cap_clr;
  assign mode    = ctrl_r[F_MODE_LO +: 2];
  assign pin_act = ctrl_r[F_PIN_LO +: 2];
  assign cap_clr = ctrl_r[F_CAPCLR_LO +: 2];

  // AHB address phase capture
  logic        wr_pend_r;
  logic [11:0] addr_r;
  logic        rd_go;
  logic        wr_go;
  assign rd_go = I_HSEL & I_HREADY & (I_HTRANS == HTRANS_NONSEQ) & ~I_HWRITE;
  assign wr_go = I_HSEL & I_HREADY & (I_HTRANS == HTRANS_NONSEQ) & I_HWRITE;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 12'h000;
    end else begin
      wr_pend_r <= wr_go;
      if (rd_go | wr_go) begin
        addr_r <= I_HADDR[11:0];
      end
    end
  end

  function automatic logic wr_hit(input logic [11:0] a);
    return wr_pend_r && (addr_r == a);
  endfunction

  // Pin edge detection on timer ticks
  logic cap_sig;
  logic cap_in;
  logic trig_rise;
  logic cap_rise;
  logic cap_fall;
  logic cap_lvl;
  assign cap_sig = (insrc_r == INSRC_PIN) ? I_CAP_PIN : I_CMP_CAP;
  assign cap_in  = ctrl_r[F_CAPSRC] ? cap_sig : I_EXT_TRIG;

  ptpc_edge u_trig (
    .i_clk   (I_CLK_SYS),
    .i_rst_b (I_RST_B),
    .i_tick  (tick),
    .i_lvl   (I_EXT_TRIG),
    .o_rise  (trig_rise),
    .o_fall  (),
    .o_lvl   ()
  );

  // Sampled at ticks: short pulses can be lost
  ptpc_edge u_cap (
    .i_clk   (I_CLK_SYS),
    .i_rst_b (I_RST_B),
    .i_tick  (tick),
    .i_lvl   (cap_in),
    .o_rise  (cap_rise),
    .o_fall  (cap_fall),
    .o_lvl   (cap_lvl)
  );

  // Mode decode
  logic is_pwm;
  logic is_pulse;
  logic is_cap;
  assign is_pwm   = (mode == MODE_PWM) && (pin_act != PIN_ACTIVE);
  assign is_pulse = (mode == MODE_PWM) && (pin_act == PIN_ACTIVE);
  assign is_cap   = (mode == MODE_CAPTURE);

  // Counter compare
  logic [CNT_W:0] period_len;
  logic           prd_match;
  logic           a_match;
  assign period_len = (period_r == '0) ? (CNT_W+1)'(1 << CNT_W)
                                       : {1'b0, period_r};
  assign prd_match  = run_r && tick && ({1'b0, cnt_r} == period_len - 1'b1);
  assign a_match    = run_r && tick && (cnt_r == cmpa_r - 1'b1) && (cmpa_r != '0);

  // Capture events
  logic cap_evt;
  logic cap_to_b;
  logic cap_clr_evt;
  always_comb begin
    case (pin_act)
      EDGE_RISE: cap_evt = cap_rise;
      EDGE_FALL: cap_evt = cap_fall;
      EDGE_BOTH: cap_evt = cap_rise | cap_fall;
      default:   cap_evt = 1'b0;
    endcase
    cap_evt = cap_evt & is_cap & run_r;
    case (cap_clr)
      CCLR_RISE: cap_clr_evt = cap_rise;
      CCLR_FALL: cap_clr_evt = cap_fall;
      CCLR_BOTH: cap_clr_evt = cap_rise | cap_fall;
      default:   cap_clr_evt = 1'b0;
    endcase
    cap_clr_evt = cap_clr_evt & is_cap & run_r;
    // Falling edge capture lands in B whenever edge clears are active
    cap_to_b = (cap_clr != '0) && cap_fall && (pin_act != EDGE_RISE);
  end

  // Run bit: software write, trigger start, compare A stop
  logic run_wr;
  logic run_rise;
  logic pulse_end;
  assign run_wr    = wr_hit(ADDR_CTRL);
  assign pulse_end = is_pulse && a_match;
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      run_r <= 1'b0;
    end else if (is_pulse && trig_rise && !run_r) begin
      run_r <= 1'b1;
    end else if (pulse_end) begin
      run_r <= 1'b0;
    end else if (run_wr) begin
      run_r <= I_HWDATA[F_RUN];
    end
  end

  logic run_d_r;
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      run_d_r <= 1'b0;
    end else begin
      run_d_r <= run_r;
    end
  end
  assign run_rise = run_r & ~run_d_r;

  // Counter
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cnt_r <= '0;
    end else if (run_rise) begin
      cnt_r <= '0;
    end else if (run_r && tick) begin
      if (is_pulse) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (prd_match || cap_clr_evt) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // Control, period, input select
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_r   <= CTRL_RESET;
      period_r <= '0;
      insrc_r  <= INSRC_PIN;
    end else begin
      if (run_wr) begin
        ctrl_r <= I_HWDATA;
      end
      if (wr_hit(ADDR_PERIOD)) begin
        period_r <= I_HWDATA[CNT_W-1:0];
      end
      if (wr_hit(ADDR_INSRC)) begin
        insrc_r <= I_HWDATA[F_INSRC_LO +: 2];
      end
    end
  end

  // Compare A / capture B; capture wins over a same-cycle write
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cmpa_r <= '0;
      capb_r <= '0;
    end else begin
      if (cap_evt && !cap_to_b) begin
        cmpa_r <= cnt_r;
      end else if (wr_hit(ADDR_CMPA)) begin
        cmpa_r <= I_HWDATA[CNT_W-1:0];
      end
      if (cap_evt && cap_to_b) begin
        capb_r <= cnt_r;
      end else if (wr_hit(ADDR_CAPB)) begin
        capb_r <= I_HWDATA[CNT_W-1:0];
      end
    end
  end

  // Flags: hardware set wins over write-one-clear
  logic set_a;
  logic set_p;
  logic lvl_pend_r;
  logic half_r;
  logic [2:0] clr_mask;
  // Capture mode reuses A as a capture register, so its match is no event
  assign set_a    = (a_match && !is_cap) || cap_evt;
  assign set_p    = prd_match && !is_pulse;
  assign clr_mask = wr_hit(ADDR_STATUS) ? I_HWDATA[2:0] : 3'h0;
  // Level flag follows half a tick period after the latch
  assign half_r   = (div_r == 16'(TCLK_DIV / 2 - 1));
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      stat_r     <= 3'h0;
      lvl_pend_r <= 1'b0;
    end else begin
      stat_r[F_FLAG_A] <= set_a | (stat_r[F_FLAG_A] & ~clr_mask[F_FLAG_A]);
      stat_r[F_FLAG_P] <= set_p | (stat_r[F_FLAG_P] & ~clr_mask[F_FLAG_P]);
      if (cap_evt) begin
        lvl_pend_r <= 1'b1;
      end else if (lvl_pend_r && half_r) begin
        lvl_pend_r       <= 1'b0;
        stat_r[F_FLAG_LVL] <= cap_lvl;
      end
    end
  end

  // Interrupt pulse
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_TMR_EVENT <= 1'b0;
    end else begin
      O_TMR_EVENT <= set_a | set_p;
    end
  end

  // Output pin
  logic pwm_act;
  logic out_nxt;
  // Internal waveform keeps running regardless of pin action
  assign pwm_act = run_r && (({1'b0, cmpa_r} >= period_len) ||
                             (cnt_r < cmpa_r));
  always_comb begin
    out_nxt = ctrl_r[F_INIT_LVL];
    if (is_pulse) begin
      out_nxt = run_r ? ~ctrl_r[F_INIT_LVL] : ctrl_r[F_INIT_LVL];
    end else if (mode == MODE_PWM) begin
      case (pin_act)
        PIN_NONE: out_nxt = 1'b0;
        PIN_LOW:  out_nxt = 1'b1;
        PIN_HIGH: out_nxt = pwm_act ? ctrl_r[F_INIT_LVL] : ~ctrl_r[F_INIT_LVL];
        default:  out_nxt = ctrl_r[F_INIT_LVL];
      endcase
    end
    out_nxt = out_nxt ^ ctrl_r[F_POL_INV];
  end
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_TMR_OUT <= 1'b0;
    end else begin
      O_TMR_OUT <= out_nxt;
    end
  end

  // Read data, registered at end of address phase
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_HRDATA <= 32'h0000_0000;
    end else if (rd_go) begin
      case (I_HADDR[11:0])
        ADDR_CTRL:   O_HRDATA <= {ctrl_r[31:1], run_r};
        ADDR_CMPA:   O_HRDATA <= 32'(cmpa_r);
        ADDR_CAPB:   O_HRDATA <= 32'(capb_r);
        ADDR_PERIOD: O_HRDATA <= 32'(period_r);
        ADDR_COUNT:  O_HRDATA <= 32'(cnt_r);
        ADDR_STATUS: O_HRDATA <= 32'(stat_r);
        ADDR_INSRC:  O_HRDATA <= 32'({insrc_r, 6'h00});
        default:     O_HRDATA <= 32'h0000_0000;
      endcase
    end
  end
endmodule // ptpc_timer

// ==== tb/ptpc_pins.sv ====
// Far-side model: start trigger, capture pin and comparator capture sources
`timescale 1ns/1ns
module ptpc_pins (
  input  wire logic i_clk,  // System clock
  output logic      o_trig, // External trigger pin
  output logic      o_cap,  // Capture pin
  output logic      o_cmp   // Comparator capture signal
);
  logic [2:0] lvl_r;
  assign o_trig = lvl_r[0];
  assign o_cap  = lvl_r[1];
  assign o_cmp  = lvl_r[2];
  initial begin
    lvl_r = 3'h0;
  end
  // Trigger pin never doubles as the tick source
  // Widths kept above two ticks so no edge may be dropped
  task pulse(input int which, input int width);
    lvl_r[which] <= 1'b1;
    repeat (width) @(posedge i_clk);
    lvl_r[which] <= 1'b0;
  endtask
endmodule // ptpc_pins

// ==== tb/ptpc_timer_asserts.sv ====
// Checker: port-level properties of the periodic timer
`timescale 1ns/1ns
module ptpc_timer_asserts
  import ptpc_pkg::*;
#(
  parameter int TCLK_DIV = TCLK_DIV_DFLT
) (
  input wire logic        I_CLK_SYS,   // Clock
  input wire logic        I_RST_B,     // Reset
  input wire logic        I_HSEL,      // Select
  input wire logic [31:0] I_HADDR,     // Address
  input wire logic [1:0]  I_HTRANS,    // Transfer type
  input wire logic        I_HWRITE,    // Write
  input wire logic [31:0] I_HWDATA,    // Write data
  input wire logic        I_HREADY,    // Ready
  input wire logic [31:0] O_HRDATA,    // Read data
  input wire logic        O_HREADYOUT, // Ready out
  input wire logic        O_HRESP,     // Response
  input wire logic        I_CAP_PIN,   // Capture pin
  input wire logic        O_TMR_OUT,   // Output pin
  input wire logic        O_TMR_EVENT  // Event pulse
);
  logic        ph_v;
  logic        ph_w;
  logic [11:0] ph_a;
  logic [10:0] ctl;
  logic [9:0]  cma;
  logic [1:0]  isr;
  logic [2:0]  age;
  logic        sp;
  logic        wr_ctl;
  assign wr_ctl = ph_v && ph_w && I_HREADY && ph_a == ADDR_CTRL;
  assign sp = ctl[2:1] == MODE_PWM && ctl[4:3] == PIN_ACTIVE;
  // Shadow of software writes only; hardware run clears are not seen
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ph_v <= 1'b0;
      ph_w <= 1'b0;
      ph_a <= 12'h000;
      ctl  <= 11'h000;
      cma  <= 10'h000;
      isr  <= 2'h0;
    end else begin
      if (I_HREADY) begin
        ph_v <= I_HSEL && I_HTRANS == HTRANS_NONSEQ;
        ph_w <= I_HWRITE;
        ph_a <= I_HADDR[11:0];
      end
      if (wr_ctl) ctl <= I_HWDATA[10:0];
      if (ph_v && ph_w && I_HREADY && ph_a == ADDR_CMPA) cma <= I_HWDATA[9:0];
      if (ph_v && ph_w && I_HREADY && ph_a == ADDR_INSRC) isr <= I_HWDATA[7:6];
    end
  end
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) age <= 3'h0;
    else if (wr_ctl) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);
  property p_rdy; O_HREADYOUT; endproperty
  a_rdy: assert property (p_rdy) else $error("ready out dropped");
  property p_resp; !O_HRESP; endproperty
  a_resp: assert property (p_resp) else $error("response not okay");
  property p_evt; O_TMR_EVENT |=> !O_TMR_EVENT; endproperty
  a_evt: assert property (p_evt) else $error("event longer than one cycle");
  property p_unm; ph_v && !ph_w && ph_a > ADDR_INSRC |-> O_HRDATA == 32'h0000_0000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_cnt; ph_v && !ph_w && ph_a == ADDR_COUNT |-> O_HRDATA[31:10] == 22'h00_0000;
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter wider than ten bits");
  property p_pwm0;
    age == 3'h7 && ctl[2:1] == MODE_PWM && ctl[4:3] == PIN_NONE && !ctl[7] |-> !O_TMR_OUT;
  endproperty
  a_pwm0: assert property (p_pwm0) else $error("forced low not low");
  property p_pwm1;
    age == 3'h7 && ctl[2:1] == MODE_PWM && ctl[4:3] == PIN_LOW && !ctl[7] |-> O_TMR_OUT;
  endproperty
  a_pwm1: assert property (p_pwm1) else $error("forced high not high");
  property p_lead;
    sp && $rose(ctl[0]) && cma > 10'h00C |-> ##[1:8] O_TMR_OUT == (!ctl[6] ^ ctl[7]);
  endproperty
  a_lead: assert property (p_lead) else $error("no pulse leading edge");
  property p_cap;
    ctl[2:1] == MODE_CAPTURE && ctl[4:3] == EDGE_RISE && ctl[8] && ctl[0] && isr == INSRC_PIN
      && age == 3'h7 && $rose(I_CAP_PIN) |-> ##[1:12] O_TMR_EVENT;
  endproperty
  a_cap: assert property (p_cap) else $error("capture edge raised no event");
  c_lead: cover property (sp && $rose(ctl[0]));
  c_cap: cover property (ctl[2:1] == MODE_CAPTURE && O_TMR_EVENT);
  c_pwm: cover property (ctl[2:1] == MODE_PWM && $rose(O_TMR_OUT));
endmodule // ptpc_timer_asserts

bind ptpc_timer ptpc_timer_asserts #(.TCLK_DIV(TCLK_DIV)) i_chk (.I_CLK_SYS, .I_RST_B,
  .I_HSEL, .I_HADDR, .I_HTRANS, .I_HWRITE, .I_HWDATA, .I_HREADY, .O_HRDATA, .O_HREADYOUT,
  .O_HRESP, .I_CAP_PIN, .O_TMR_OUT, .O_TMR_EVENT);

// ==== tb/periodic_timer_pwm_pulse_capture_test.sv ====
// Testbench: register tasks and mode scenarios for the periodic timer
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD %0t got %0h exp %0h", $time, (a), (e)); end end
module periodic_timer_pwm_pulse_capture_test;
  import ptpc_pkg::*;
  localparam int D = 2;
  logic        clk, rst_b, hsel, hwrite, hrdyo, hresp, trig, cap, cmp, tout, tevt;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  int          miscompares, total_checks, evts, n, k, e0;
  ptpc_timer #(.TCLK_DIV(D)) i_dut (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HWDATA(hwdata), .I_HREADY(hrdyo), .O_HRDATA(hrdata), .O_HREADYOUT(hrdyo),
    .O_HRESP(hresp), .I_EXT_TRIG(trig), .I_CAP_PIN(cap), .I_CMP_CAP(cmp),
    .O_TMR_OUT(tout), .O_TMR_EVENT(tevt));
  ptpc_pins i_pins (.i_clk(clk), .o_trig(trig), .o_cap(cap), .o_cmp(cmp));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (tevt === 1'b1) evts++;
  task final_report;
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task hold;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdyo !== 1'b1 && n < 50);
    if (hrdyo !== 1'b1) begin
      miscompares++;
      final_report;
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans <= HTRANS_NONSEQ;
    haddr  <= {20'h0_0000, a};
    hwrite <= w;
    hold;
    htrans <= 2'h0;
    hwdata <= d;
    hold;
    q = hrdata;
  endtask
  // A level that never comes is a mismatch and ends the run
  task wait_out(input logic v, input int lim, output int c);
    c = 0;
    while (tout !== v && c < lim) begin
      @(negedge clk);
      c++;
    end
    if (tout !== v) begin
      miscompares++;
      final_report;
    end
    @(posedge clk);
  endtask
  function automatic logic [31:0] cw(input logic [1:0] m, p, input logic lvl, inv, cs,
                                     input logic [1:0] cc, input logic b5, run);
    return {21'h00_0000, cc, cs, inv, lvl, b5, p, m, run};
  endfunction
  // Window is whole periods, so the high count is phase independent
  task pwm(input int per, cma, input logic [1:0] p, input logic lvl, inv, b5, input int ex);
    int hi;
    xfer(1'b1, ADDR_CTRL, 32'h0000_0000);
    xfer(1'b1, ADDR_PERIOD, 32'(per));
    xfer(1'b1, ADDR_CMPA, 32'(cma));
    xfer(1'b1, ADDR_CTRL, cw(MODE_PWM, p, lvl, inv, 1'b0, 2'h0, b5, 1'b1));
    repeat (20) @(posedge clk);
    hi = 0;
    repeat ((per == 0 ? 1024 : per) * D * 8) begin
      @(negedge clk);
      hi += int'(tout === 1'b1);
    end
    @(posedge clk);
    `CHK(hi, ex)
  endtask
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {miscompares, total_checks, evts} = '0;
    rst_b = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    hsel  <= 1'b1;
    @(posedge clk);
    xfer(1'b0, ADDR_CTRL, 32'h0000_0000);
    `CHK(q, CTRL_RESET)
    xfer(1'b0, 12'h01C, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    pwm(4, 1, PIN_HIGH, 1'b1, 1'b0, 1'b0, 16);
    pwm(4, 4, PIN_HIGH, 1'b1, 1'b0, 1'b0, 64);
    pwm(4, 6, PIN_HIGH, 1'b1, 1'b0, 1'b0, 64);
    pwm(4, 1, PIN_HIGH, 1'b1, 1'b1, 1'b0, 48);
    pwm(4, 1, PIN_HIGH, 1'b0, 1'b0, 1'b0, 48);
    pwm(4, 1, PIN_HIGH, 1'b1, 1'b0, 1'b1, 16);
    pwm(0, 512, PIN_HIGH, 1'b1, 1'b0, 1'b0, 8192);
    pwm(4, 1, PIN_LOW, 1'b1, 1'b0, 1'b0, 64);
    pwm(4, 1, PIN_NONE, 1'b1, 1'b0, 1'b0, 0);
    xfer(1'b0, ADDR_COUNT, 32'h0000_0000);
    e0 = int'(q[9:0]);
    xfer(1'b0, ADDR_COUNT, 32'h0000_0000);
    `CHK(int'(q[9:0]) != e0, 1'b1)
    xfer(1'b1, ADDR_CTRL, cw(MODE_PWM, PIN_ACTIVE, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
    xfer(1'b1, ADDR_PERIOD, 32'h0000_0002);
    xfer(1'b1, ADDR_CMPA, 32'h0000_0005);
    e0 = evts;
    xfer(1'b1, ADDR_CTRL, cw(MODE_PWM, PIN_ACTIVE, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1));
    wait_out(1'b1, 20, k);
    wait_out(1'b0, 40, k);
    `CHK(k >= 4 * D && k <= 6 * D, 1'b1)
    xfer(1'b0, ADDR_CTRL, 32'h0000_0000);
    `CHK(q[F_RUN], 1'b0)
    `CHK(evts > e0, 1'b1)
    xfer(1'b0, ADDR_COUNT, 32'h0000_0000);
    `CHK(q[9:0], 10'h005)
    xfer(1'b1, ADDR_CTRL, cw(MODE_PWM, PIN_ACTIVE, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
    i_pins.pulse(0, 8);
    wait_out(1'b1, 20, k);
    `CHK(k < 20, 1'b1)
    wait_out(1'b0, 40, k);
    xfer(1'b1, ADDR_CMPA, 32'h0000_012C);
    xfer(1'b1, ADDR_CTRL, cw(MODE_PWM, PIN_ACTIVE, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1));
    repeat (20) @(posedge clk);
    xfer(1'b1, ADDR_CTRL, cw(MODE_PWM, PIN_ACTIVE, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
    wait_out(1'b0, 40, k);
    `CHK(k < 8, 1'b1)
    xfer(1'b1, ADDR_PERIOD, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, ADDR_CTRL, 32'h0000_0000);
      xfer(1'b1, ADDR_INSRC, (i == 2) ? 32'h0000_0040 : 32'h0000_0000);
      xfer(1'b1, ADDR_STATUS, 32'h0000_0007);
      xfer(1'b1, ADDR_CTRL, cw(MODE_CAPTURE, EDGE_RISE, 1'b0, 1'b0, i != 0, 2'h0, 1'b0, 1'b1));
      repeat (30) @(posedge clk);
      i_pins.pulse(i, 8);
      repeat (6) @(posedge clk);
      // Level flag left unchecked with clear select 00
      xfer(1'b0, ADDR_STATUS, 32'h0000_0000);
      `CHK(q[F_FLAG_A], 1'b1)
      xfer(1'b0, ADDR_CMPA, 32'h0000_0000);
      `CHK(q[9:0] > 10'h00A, 1'b1)
    end
    // Back to the pin, the last pass left the comparator selected
    xfer(1'b1, ADDR_INSRC, 32'h0000_0000);
    xfer(1'b1, ADDR_STATUS, 32'h0000_0007);
    xfer(1'b1, ADDR_CTRL, cw(MODE_CAPTURE, EDGE_OFF, 1'b0, 1'b0, 1'b1, 2'h0, 1'b0, 1'b1));
    i_pins.pulse(1, 8);
    repeat (6) @(posedge clk);
    xfer(1'b0, ADDR_STATUS, 32'h0000_0000);
    `CHK(q[F_FLAG_A], 1'b0)
    xfer(1'b1, ADDR_CTRL, cw(MODE_CAPTURE, EDGE_BOTH, 1'b0, 1'b0, 1'b1, CCLR_FALL, 1'b0, 1'b1));
    repeat (30) @(posedge clk);
    i_pins.pulse(1, 20);
    repeat (4) @(posedge clk);
    xfer(1'b0, ADDR_COUNT, 32'h0000_0000);
    `CHK(q[9:0] < 10'h00A, 1'b1)
    xfer(1'b0, ADDR_CAPB, 32'h0000_0000);
    `CHK(q[9:0] > 10'h00A, 1'b1)
    xfer(1'b1, ADDR_PERIOD, 32'h0000_0006);
    xfer(1'b1, ADDR_STATUS, 32'h0000_0007);
    repeat (40) @(posedge clk);
    xfer(1'b0, ADDR_STATUS, 32'h0000_0000);
    `CHK(q[F_FLAG_P], 1'b1)
    xfer(1'b0, ADDR_COUNT, 32'h0000_0000);
    `CHK(q[9:0] < 10'h007, 1'b1)
    final_report;
  end
endmodule // periodic_timer_pwm_pulse_capture_test
